// ---- src_pkg.sv ----
// Package of offsets, field layouts, reset values and types for the recovery control registers.
package src_pkg;

	// ==========================================================================
	// Register map
	localparam logic [14:0] SRC_ADDR_RESET_CTRL = 15'h0206;
	localparam logic [14:0] SRC_ADDR_OPMODE     = 15'h0230;
	localparam logic [14:0] SRC_ADDR_EQ_CONFIG  = 15'h0250;

	// ==========================================================================
	// Reset values and writable bit masks
	localparam logic [7:0]  SRC_RST_RESET_CTRL  = 8'h01;
	localparam logic [7:0]  SRC_RST_OPMODE      = 8'h28;
	localparam logic [7:0]  SRC_RST_EQ_CONFIG   = 8'h80;
	localparam logic [7:0]  SRC_MASK_RESET_CTRL = 8'h01;
	localparam logic [7:0]  SRC_MASK_OPMODE     = 8'h3E;
	localparam logic [7:0]  SRC_MASK_EQ_CONFIG  = 8'hF0;

	// ==========================================================================
	// Field positions
	localparam int          SRC_RUN_BIT         = 0;
	localparam int          SRC_HALF_RATE_BIT   = 5;
	localparam int          SRC_DIV_LSB         = 1;
	localparam int          SRC_EQ_LSB          = 4;
	localparam logic [3:0]  SRC_EQ_MANUAL_CODE  = 4'h0;

	// ==========================================================================
	// Serial frame timing
	localparam logic [4:0]  SRC_INSTR_LAST      = 5'h0F;
	localparam logic [4:0]  SRC_FRAME_LAST      = 5'h17;

	typedef enum logic [1:0] {
		SRC_IDLE,
		SRC_INSTR,
		SRC_DATA,
		SRC_DONE
	} src_state_e;

	typedef struct packed {
		logic       recovery_reset;
		logic       half_rate;
		logic [1:0] oversample_div;
		logic       eq_manual;
		logic [3:0] eq_boost;
	} src_ctrl_s;

endpackage : src_pkg

// ---- src_recovery_regs.sv ----
// Serial-port register bank for receive clock recovery and equalizer control.
`timescale 1ns/1ps
module src_recovery_regs
	import src_pkg::*;
(
	input  wire logic      core_clk,
	input  wire logic      srst,
	input  wire logic      spi_csb_n,
	input  wire logic      spi_sclk,
	input  wire logic      spi_sdi,
	output logic           spi_sdo,
	output logic           spi_sdo_oe,
	output src_ctrl_s      ctrl
);

	// ==========================================================================
	// Serial port front end
	// The serial clock is oversampled, so it must stay well below a quarter of core_clk.
	logic       sclk_reg;
	logic       sclk_rise;
	logic       sclk_fall;
	src_state_e state_reg,  state_next;
	logic [4:0] cnt_reg,    cnt_next;
	logic [15:0] sh_reg,    sh_next;
	logic       rd_reg,     rd_next;
	logic [14:0] addr_reg,  addr_next;
	logic [7:0] out_reg,    out_next;
	logic       sdo_reg,    sdo_next;
	logic       oe_reg,     oe_next;
	logic       wr_stb;
	logic [7:0] wr_data;

	// ==========================================================================
	// Read decode
	function automatic logic [7:0] rd_value(input logic [14:0] a, input logic [7:0] rc,
		input logic [7:0] om, input logic [7:0] eq);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			SRC_ADDR_RESET_CTRL: v = rc;
			SRC_ADDR_OPMODE:     v = om;
			SRC_ADDR_EQ_CONFIG:  v = eq;
			// Unmapped addresses all answer zero.
			default:             v = 8'h00;
		endcase
		return v;
	endfunction : rd_value

	logic [7:0] rc_reg, rc_next;
	logic [7:0] om_reg, om_next;
	logic [7:0] eq_reg, eq_next;

	// The previous sample resets low like an idle serial clock, so no false edge follows reset.
	assign sclk_rise = spi_sclk & ~sclk_reg;
	assign sclk_fall = ~spi_sclk & sclk_reg;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		sh_next    = sh_reg;
		rd_next    = rd_reg;
		addr_next  = addr_reg;
		out_next   = out_reg;
		sdo_next   = sdo_reg;
		oe_next    = oe_reg;
		wr_stb     = 1'b0;
		wr_data    = sh_reg[7:0];
		if (spi_csb_n) begin
			// Chip select high cuts any frame short before its write strobe.
			state_next = SRC_IDLE;
			cnt_next   = 5'h00;
			sdo_next   = 1'b0;
			oe_next    = 1'b0;
		end else begin
			case (state_reg)
				SRC_IDLE: begin
					// One idle cycle lets the edge detector settle on the new frame.
					state_next = SRC_INSTR;
					cnt_next   = 5'h00;
				end
				SRC_INSTR: begin
					if (sclk_rise) begin
						sh_next  = {sh_reg[14:0], spi_sdi};
						cnt_next = 5'(cnt_reg + 5'h01);
						// The read byte is captured here, so it shows the register as addressed.
						if (cnt_reg == SRC_INSTR_LAST) begin
							rd_next    = sh_reg[14];
							addr_next  = {sh_reg[13:0], spi_sdi};
							out_next   = rd_value({sh_reg[13:0], spi_sdi}, rc_reg, om_reg, eq_reg);
							state_next = SRC_DATA;
						end
					end
				end
				SRC_DATA: begin
					// Read data leaves on the falling edge so the host can sample it on the rise.
					if (sclk_fall && rd_reg) begin
						sdo_next = out_reg[7];
						oe_next  = 1'b1;
						out_next = {out_reg[6:0], 1'b0};
					end
					if (sclk_rise) begin
						sh_next  = {sh_reg[14:0], spi_sdi};
						cnt_next = 5'(cnt_reg + 5'h01);
						// The strobe fires only on the last bit, so a partial byte writes nothing.
						if (cnt_reg == SRC_FRAME_LAST) begin
							wr_stb     = ~rd_reg;
							wr_data    = {sh_reg[6:0], spi_sdi};
							state_next = SRC_DONE;
						end
					end
				end
				SRC_DONE: begin
					// Extra clocks after one byte are ignored until chip select rises.
					state_next = SRC_DONE;
				end
				default: state_next = SRC_IDLE;
			endcase
		end
	end

	// Reset drops any frame in flight; the host must send it again.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			sclk_reg  <= 1'b0;
			state_reg <= SRC_IDLE;
			cnt_reg   <= 5'h00;
			sh_reg    <= 16'h0000;
			rd_reg    <= 1'b0;
			addr_reg  <= 15'h0000;
			out_reg   <= 8'h00;
			sdo_reg   <= 1'b0;
			oe_reg    <= 1'b0;
		end else begin
			sclk_reg  <= spi_sclk;
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			sh_reg    <= sh_next;
			rd_reg    <= rd_next;
			addr_reg  <= addr_next;
			out_reg   <= out_next;
			sdo_reg   <= sdo_next;
			oe_reg    <= oe_next;
		end
	end

	// ==========================================================================
	// Register storage
	// Reserved bits are masked on write, so they keep their reset values.
	always_comb begin
		rc_next = rc_reg;
		om_next = om_reg;
		eq_next = eq_reg;
		if (wr_stb) begin
			case (addr_reg)
				SRC_ADDR_RESET_CTRL: begin
					// Only the run bit exists; the other bits read zero.
					rc_next = wr_data & SRC_MASK_RESET_CTRL;
				end
				SRC_ADDR_OPMODE: begin
					om_next = (om_reg & ~SRC_MASK_OPMODE) | (wr_data & SRC_MASK_OPMODE);
				end
				SRC_ADDR_EQ_CONFIG: begin
					eq_next = wr_data & SRC_MASK_EQ_CONFIG;
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			rc_reg <= SRC_RST_RESET_CTRL;
			om_reg <= SRC_RST_OPMODE;
			eq_reg <= SRC_RST_EQ_CONFIG;
		end else begin
			rc_reg <= rc_next;
			om_reg <= om_next;
			eq_reg <= eq_next;
		end
	end

	// ==========================================================================
	// Control outputs
	// Decoded into flops so the recovery datapath sees glitch-free levels.
	// One decoder feeds both the reset value and the running value, so they cannot drift apart.
	function automatic src_ctrl_s ctrl_decode(input logic [7:0] rc, input logic [7:0] om, input logic [7:0] eq);
		src_ctrl_s c;
		c                = '0;
		c.recovery_reset = ~rc[SRC_RUN_BIT];
		c.half_rate      = om[SRC_HALF_RATE_BIT];
		c.oversample_div = om[SRC_DIV_LSB +: 2];
		c.eq_boost       = eq[SRC_EQ_LSB +: 4];
		c.eq_manual      = (eq[SRC_EQ_LSB +: 4] == SRC_EQ_MANUAL_CODE);
		return c;
	endfunction : ctrl_decode

	src_ctrl_s ctrl_reg, ctrl_next;

	always_comb begin
		ctrl_next = ctrl_decode(rc_reg, om_reg, eq_reg);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			ctrl_reg <= ctrl_decode(SRC_RST_RESET_CTRL, SRC_RST_OPMODE, SRC_RST_EQ_CONFIG);
		end else begin
			ctrl_reg <= ctrl_next;
		end
	end

	// ==========================================================================
	// Outputs
	assign ctrl       = ctrl_reg;
	assign spi_sdo    = sdo_reg;
	assign spi_sdo_oe = oe_reg;

endmodule : src_recovery_regs

// ---- src_recovery_regs_bench.sv ----
// Testbench for the recovery control register bank.
`timescale 1ns/1ps
module src_recovery_regs_bench;
	import src_pkg::*;
	logic      core_clk = 1'b0;
	logic      srst     = 1'b1;
	logic      csb_n    = 1'b1;
	logic      sclk     = 1'b0;
	logic      sdi      = 1'b0;
	logic      sdo;
	logic      oe;
	src_ctrl_s ctrl;
	int        error_cnt  = 0;
	int        n_compared = 0;
	int        cyc        = 0;
	logic [7:0] r;
	logic       o;
	src_recovery_regs dut (.core_clk(core_clk), .srst(srst), .spi_csb_n(csb_n), .spi_sclk(sclk),
		.spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(oe), .ctrl(ctrl));
	always #10 core_clk = ~core_clk;
	// ==========================================================================
	// Tasks
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tk
	task automatic close_out;
		$display("errors %0d compared %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic cmp(input logic [8:0] g, input logic [8:0] e);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	// Each serial half period spans three core cycles so the edge detector sees it.
	// A frame that stops before bit 0 is cut by chip select and must write nothing.
	task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, input int lo);
		logic [23:0] sh;
		sh = {ins, wd};
		csb_n = 1'b0;
		for (int i = 23; i >= lo; i--) begin
			sdi = sh[i];
			tk(3);
			sclk = 1'b1;
			tk(3);
			if (i < 8) r[i] = sdo;
			if (i == lo) o = oe;
			sclk = 1'b0;
		end
		tk(3);
		csb_n = 1'b1;
		tk(3);
	endtask : xfer
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		xfer({1'b0, a}, d, 0);
	endtask : wr
	task automatic chk(input logic [14:0] a, input logic [7:0] e);
		xfer({1'b1, a}, 8'h00, 0);
		cmp({1'b0, r}, {1'b0, e});
		cmp({6'h00, o, oe, sdo}, 9'h004);
	endtask : chk
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out();
		end
	end
	// ==========================================================================
	// Tests
	initial begin
		tk(3);
		srst = 1'b0;
		cmp(ctrl, 9'h088);
		chk(SRC_ADDR_RESET_CTRL, 8'h01);
		chk(SRC_ADDR_OPMODE, 8'h28);
		chk(SRC_ADDR_EQ_CONFIG, 8'h80);
		wr(SRC_ADDR_RESET_CTRL, 8'h00);
		cmp(ctrl, 9'h188);
		chk(SRC_ADDR_RESET_CTRL, 8'h00);
		wr(SRC_ADDR_RESET_CTRL, 8'hFF);
		cmp(ctrl, 9'h088);
		wr(SRC_ADDR_OPMODE, 8'h00);
		cmp(ctrl, 9'h008);
		chk(SRC_ADDR_OPMODE, 8'h00);
		for (int d = 0; d < 4; d++) begin
			wr(SRC_ADDR_OPMODE, {5'h05, 2'(d), 1'b1});
			cmp(ctrl, {2'b01, 2'(d), 5'h08});
			chk(SRC_ADDR_OPMODE, {5'h05, 2'(d), 1'b0});
		end
		for (int c = 0; c < 16; c++) begin
			wr(SRC_ADDR_EQ_CONFIG, {4'(c), 4'hF});
			cmp(ctrl, {4'h7, c == 0, 4'(c)});
			chk(SRC_ADDR_EQ_CONFIG, {4'(c), 4'h0});
		end
		xfer({1'b0, SRC_ADDR_EQ_CONFIG}, 8'h00, 1);
		cmp(ctrl, 9'h0EF);
		chk(SRC_ADDR_EQ_CONFIG, 8'hF0);
		wr(15'h0231, 8'hFF);
		chk(15'h0231, 8'h00);
		wr(SRC_ADDR_RESET_CTRL, 8'h00);
		srst = 1'b1;
		tk(3);
		srst = 1'b0;
		cmp(ctrl, 9'h088);
		chk(SRC_ADDR_RESET_CTRL, 8'h01);
		chk(SRC_ADDR_OPMODE, 8'h28);
		chk(SRC_ADDR_EQ_CONFIG, 8'h80);
		close_out();
	end
endmodule : src_recovery_regs_bench
bind src_recovery_regs src_props u_props (.core_clk(core_clk), .srst(srst), .spi_csb_n(spi_csb_n),
	.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .ctrl(ctrl));

// ---- src_recovery_regs_props.sv ----
// Checker for the recovery control register bank.
`timescale 1ns/1ps
module src_props
	import src_pkg::*;
(
	input wire logic      core_clk,
	input wire logic      srst,
	input wire logic      spi_csb_n,
	input wire logic      spi_sdo,
	input wire logic      spi_sdo_oe,
	input wire src_ctrl_s ctrl
);
	// ==========================================================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	a_reset_ctrl: assert property ($fell(srst) |-> ctrl == 9'h088)
		else $error("ctrl not at reset value");
	a_eq_manual: assert property (ctrl.eq_manual == (ctrl.eq_boost == 4'h0))
		else $error("manual flag disagrees with boost code");
	// Writes only land inside a frame, so an idle port must leave the outputs alone.
	a_ctrl_quiet: assert property (spi_csb_n && $past(spi_csb_n, 2) |-> $stable(ctrl))
		else $error("ctrl changed outside a frame");
	a_oe_idle: assert property (spi_csb_n && $past(spi_csb_n) |-> !spi_sdo_oe && !spi_sdo)
		else $error("serial output active while idle");
endmodule : src_props
